// >>> src/cms_params.svh
// Constants for the charger mode and fault supervisor
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH
`define CMS_CLK_HZ          10000000
`define CMS_PULSE_NS        128000
`define CMS_PULSE_CYC       ((`CMS_PULSE_NS * 10) / 1000)
`define CMS_BOOST_TMR_S     32
`define CMS_BOOST_TMR_CYC   (`CMS_BOOST_TMR_S * `CMS_CLK_HZ)
`define CMS_SOFT_CYC        16'h0100
`define CMS_ADDR_CTRL       4'h0
`define CMS_ADDR_STAT       4'h4
`define CMS_ADDR_IRQ        4'h8
`define CMS_ADDR_MASK       4'hC
`define CMS_CTRL_RST        8'h00
`define CMS_B_CHG_DIS       0
`define CMS_B_HIZ           1
`define CMS_B_OPSEL         2
`define CMS_B_KICK          3
`define CMS_B_PRST          4
`define CMS_B_STAT_EN       5
`define CMS_B_FCLR          6
`endif

// >>> src/cms_pkg.sv
// Types for the charger mode and fault supervisor
package cms_pkg;
    typedef enum logic [2:0] {
        CMS_HIZ, CMS_CFG, CMS_CHARGE, CMS_SOFT, CMS_BOOST
    } cms_mode_t;
endpackage

// >>> src/cms_top.sv
// Mode selection, boost timer and fault supervision for the charger
`timescale 1ns/1ps
`include "cms_params.svh"

// Operation
// [R1] Charge fault gives one status pulse
// [R2] Boost fault gives one status pulse
// [R3] Charge disable bit inhibits charging
// [R4] Parameter reset restores defaults, self-clears
// [R5] Host avoids parameter reset while active
// [R6] Select low: charge, configure or hiz
// [R7] Select high: boost, fault gives configure
// [R8] OTG input or select bit enters boost
// [R9] Boost start launches 32 s timer
// [R10] Kick bit restarts timer, self-clears
// [R11] Host kicks timer before expiry
// [R12] Expiry stops boost, latched fault
// [R13] Bus overvoltage clears select, faults
// [R14] Resume needs select write or OTG
// [R15] Light load pulse skipping with hysteresis
// [R16] Soft start whenever boost begins
// [R17] Status low while charging if enabled
// [R18] Pulse drives open-drain pin low
module cms_top
    import cms_pkg::*;
#(
    parameter int BOOST_TMR_CYC = `CMS_BOOST_TMR_CYC
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       otg_pin,
    input  wire logic       vbus_above_uvlo,
    input  wire logic       chg_fault,
    input  wire logic       bst_fault,
    input  wire logic       vbus_ovp,
    input  wire logic       ind_i_low,
    input  wire logic       node_sag,
    output logic            charge_en,
    output logic            boost_en,
    output logic            soft_start,
    output logic            pwm_en,
    output logic            param_reset,
    output logic            stat_o,
    output logic            stat_oe_n,
    output logic            irq
);

    // Pin inputs pass two flip-flops
    logic [6:0] s1_q;
    logic [6:0] s2_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_q <= 7'h00;
            s2_q <= 7'h00;
        end else begin
            s1_q <= {otg_pin, vbus_above_uvlo, chg_fault, bst_fault,
                     vbus_ovp, ind_i_low, node_sag};
            s2_q <= s1_q;
        end
    end
    logic otg;
    logic uvlo_ok;
    logic cflt;
    logic bflt;
    logic ovp;
    logic ilow;
    logic sag;
    assign {otg, uvlo_ok, cflt, bflt, ovp, ilow, sag} = s2_q;

    logic [7:0]  ctrl_q;
    logic [3:0]  irq_q;
    logic [3:0]  mask_q;
    logic        tmr_fault_q;
    logic        bst_flt_q;
    logic [31:0] tmr_q;
    logic [15:0] soft_q;
    logic [11:0] pulse_q;
    logic        skip_q;
    logic        cflt_q;
    cms_mode_t   mode_q;
    cms_mode_t   mode_d;

    logic wr_ctrl;
    logic rd_irq;
    logic boost_req;
    logic any_bfault;
    logic tmr_expire;
    assign wr_ctrl    = wr && (addr == `CMS_ADDR_CTRL);
    assign rd_irq     = rd && (addr == `CMS_ADDR_IRQ);
    // [R8] [R14] OTG or select
    assign boost_req  = otg || ctrl_q[`CMS_B_OPSEL];
    assign any_bfault = bflt || ovp || tmr_fault_q || bst_flt_q;
    assign tmr_expire = (mode_q == CMS_BOOST || mode_q == CMS_SOFT)
                        && (tmr_q == 32'h00000001);

    // Control register with self-clearing and forced bits
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= `CMS_CTRL_RST;
        end else begin
            // [R4] Reset self-clears, a new write still lands
            if (ctrl_q[`CMS_B_PRST]) begin
                ctrl_q <= `CMS_CTRL_RST;
            end
            if (wr_ctrl) begin
                ctrl_q <= wdata;
            end
            // [R10] Kick self-clears
            if (ctrl_q[`CMS_B_KICK] && !wr_ctrl) begin
                ctrl_q[`CMS_B_KICK] <= 1'b0;
            end
            if (ctrl_q[`CMS_B_FCLR] && !wr_ctrl) begin
                ctrl_q[`CMS_B_FCLR] <= 1'b0;
            end
            // [R13] Overvoltage clears select
            if (ovp && mode_q != CMS_HIZ && mode_q != CMS_CHARGE
                    && mode_q != CMS_CFG) begin
                ctrl_q[`CMS_B_OPSEL] <= 1'b0;
            end
        end
    end

    // [R12] Latched boost faults until host clears
    always_ff @(posedge clk) begin
        if (reset) begin
            tmr_fault_q <= 1'b0;
            bst_flt_q   <= 1'b0;
        end else begin
            if (ctrl_q[`CMS_B_FCLR]) begin
                tmr_fault_q <= 1'b0;
                bst_flt_q   <= 1'b0;
            end
            if (tmr_expire) begin
                tmr_fault_q <= 1'b1;
            end
            if ((mode_q == CMS_BOOST || mode_q == CMS_SOFT) && bflt) begin
                bst_flt_q <= 1'b1;
            end
        end
    end

    // Mode selection
    always_comb begin
        mode_d = mode_q;
        // [R6] Hiz request wins unless the OTG input is high
        if (ctrl_q[`CMS_B_HIZ] && !otg) begin
            mode_d = CMS_HIZ;
        end else if (boost_req) begin
            // [R7] Fault goes to configure
            if (any_bfault) begin
                mode_d = CMS_CFG;
            // [R16] Soft start first
            end else if (mode_q != CMS_BOOST && mode_q != CMS_SOFT) begin
                mode_d = CMS_SOFT;
            end else if (mode_q == CMS_SOFT && soft_q == 16'h0000) begin
                mode_d = CMS_BOOST;
            end
        // [R6] Charge mode choice
        end else if (!uvlo_ok) begin
            mode_d = CMS_HIZ;
        end else if (cflt || ctrl_q[`CMS_B_CHG_DIS]) begin
            // [R3] Disable inhibits
            mode_d = CMS_CFG;
        end else begin
            mode_d = CMS_CHARGE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q <= CMS_HIZ;
        end else begin
            mode_q <= mode_d;
        end
    end

    // [R16] Soft start counter
    always_ff @(posedge clk) begin
        if (reset) begin
            soft_q <= 16'h0000;
        end else if (mode_q != CMS_SOFT && mode_d == CMS_SOFT) begin
            soft_q <= `CMS_SOFT_CYC;
        end else if (soft_q != 16'h0000) begin
            soft_q <= soft_q - 16'h0001;
        end
    end

    // [R9] Boost safety timer
    always_ff @(posedge clk) begin
        if (reset) begin
            tmr_q <= 32'h00000000;
        end else if (mode_q != CMS_SOFT && mode_d == CMS_SOFT) begin
            tmr_q <= 32'(BOOST_TMR_CYC);
        // [R10] Kick restarts
        end else if (ctrl_q[`CMS_B_KICK]) begin
            tmr_q <= 32'(BOOST_TMR_CYC);
        end else if (tmr_q != 32'h00000000) begin
            tmr_q <= tmr_q - 32'h00000001;
        end
    end

    // [R15] Pulse skipping hysteresis
    always_ff @(posedge clk) begin
        if (reset) begin
            skip_q <= 1'b0;
        end else if (mode_q != CMS_BOOST) begin
            skip_q <= 1'b0;
        end else if (skip_q && sag) begin
            skip_q <= 1'b0;
        end else if (ilow) begin
            skip_q <= 1'b1;
        end
    end

    // Fault event edges feed status pulse and interrupts
    logic chg_evt;
    logic bst_evt;
    always_ff @(posedge clk) begin
        if (reset) begin
            cflt_q <= 1'b0;
        end else begin
            cflt_q <= cflt;
        end
    end
    assign chg_evt = cflt && !cflt_q && !boost_req;
    assign bst_evt = (mode_q == CMS_BOOST || mode_q == CMS_SOFT)
                     && mode_d == CMS_CFG;

    // [R1] [R2] Fault pulse timer
    always_ff @(posedge clk) begin
        if (reset) begin
            pulse_q <= 12'h000;
        end else if (chg_evt || bst_evt) begin
            pulse_q <= 12'(`CMS_PULSE_CYC);
        end else if (pulse_q != 12'h000) begin
            pulse_q <= pulse_q - 12'h001;
        end
    end

    // Sticky status, set wins over read clear
    logic [3:0] ev;
    assign ev = {ovp && bst_evt, tmr_expire, bst_evt, chg_evt};
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 4'h0;
        end else if (rd_irq) begin
            irq_q <= ev;
        end else begin
            irq_q <= irq_q | ev;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mask_q <= 4'h0;
        end else if (wr && addr == `CMS_ADDR_MASK) begin
            mask_q <= wdata[3:0];
        end
    end

    // Read data one cycle after strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (rd) begin
            if (addr == `CMS_ADDR_CTRL) begin
                rdata <= ctrl_q;
            end else if (addr == `CMS_ADDR_STAT) begin
                rdata <= {1'b0, skip_q, bst_flt_q, tmr_fault_q,
                          2'b00, 2'(int'(mode_q) > 3 ? 3 : int'(mode_q))};
            end else if (addr == `CMS_ADDR_IRQ) begin
                rdata <= {4'h0, irq_q};
            end else if (addr == `CMS_ADDR_MASK) begin
                rdata <= {4'h0, mask_q};
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            charge_en   <= 1'b0;
            boost_en    <= 1'b0;
            soft_start  <= 1'b0;
            pwm_en      <= 1'b0;
            param_reset <= 1'b0;
            stat_o      <= 1'b0;
            stat_oe_n   <= 1'b1;
            irq         <= 1'b0;
        end else begin
            charge_en   <= (mode_d == CMS_CHARGE);
            // [R12] [R13] Boost off on fault
            boost_en    <= (mode_d == CMS_BOOST || mode_d == CMS_SOFT);
            soft_start  <= (mode_d == CMS_SOFT);
            // [R15] Skip gates switching
            pwm_en      <= (mode_d == CMS_CHARGE || mode_d == CMS_SOFT
                            || (mode_d == CMS_BOOST && !skip_q));
            param_reset <= ctrl_q[`CMS_B_PRST];
            stat_o      <= 1'b0;
            // [R18] [R17] Pull low for pulse or charge
            stat_oe_n   <= !((pulse_q != 12'h000) || chg_evt || bst_evt
                             || (mode_q == CMS_CHARGE
                                 && ctrl_q[`CMS_B_STAT_EN]));
            irq         <= |((irq_q | ev) & mask_q);
        end
    end

endmodule

// >>> verification/cms_host_model.sv
// Host side model: pulled-up status pin and pulse length meter
`timescale 1ns/1ps
module cms_host_model (
    input  wire logic clk,
    input  wire logic stat_o,
    input  wire logic stat_oe_n,
    output logic      stat_pin,
    output int        low_len
);
    int run = 0;
    int last_q = 0;
    // Length of the last completed low stretch
    assign low_len = last_q;
    assign stat_pin = stat_oe_n ? 1'b1 : stat_o;
    // Keeps the length of the last low stretch
    always @(posedge clk) begin
        if (!stat_pin) run <= run + 1;
        else begin
            if (run != 0) last_q <= run;
            run <= 0;
        end
    end
endmodule

// >>> verification/cms_top_sva.sv
// Property checker for the charger mode and fault supervisor
`timescale 1ns/1ps
`include "cms_params.svh"
module cms_top_sva
    import cms_pkg::*;
#(
    parameter int BOOST_TMR_CYC = `CMS_BOOST_TMR_CYC
) (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       wr,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       chg_fault,
    input wire logic       bst_fault,
    input wire logic       vbus_ovp,
    input wire logic       param_reset,
    input wire logic       charge_en,
    input wire logic       boost_en,
    input wire logic       soft_start,
    input wire logic       stat_o,
    input wire logic       stat_oe_n,
    input wire logic       irq
);
    int   low_q;
    int   tmr_q;
    logic kick;
    logic prst_wr;
    // Control writes that restart the timer or reset parameters
    assign kick    = wr && addr == `CMS_ADDR_CTRL && wdata[`CMS_B_KICK];
    assign prst_wr = wr && addr == `CMS_ADDR_CTRL && wdata[`CMS_B_PRST];
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Length of a status low stretch outside charging
    always_ff @(posedge clk) begin
        if (reset || stat_oe_n || charge_en) low_q <= 0;
        else low_q <= low_q + 1;
    end
    // Boost time since start or last kick
    always_ff @(posedge clk) begin
        if (reset || !boost_en || kick) tmr_q <= 0;
        else tmr_q <= tmr_q + 1;
    end
    a_drive_zero: assert property (!stat_o)
        else $error("status drive value not low");
    a_prst_start: assert property (prst_wr |-> ##[1:3] param_reset)
        else $error("parameter reset pulse missing");
    a_prst_clear: assert property (param_reset |=> !param_reset)
        else $error("parameter reset longer than one cycle");
    a_mode_excl: assert property (!(charge_en && boost_en))
        else $error("charge and boost both enabled");
    a_soft_first: assert property ($rose(boost_en) |-> soft_start)
        else $error("boost began without soft start");
    a_ovp_stop: assert property ($rose(vbus_ovp) && boost_en
        |-> ##[1:5] !boost_en)
        else $error("boost kept running on overvoltage");
    a_chg_pulse: assert property ($rose(chg_fault) && charge_en
        |-> ##[2:6] !stat_oe_n)
        else $error("no status pulse on charge fault");
    a_bst_pulse: assert property ($rose(bst_fault) && boost_en
        |-> ##[2:6] !stat_oe_n)
        else $error("no status pulse on boost fault");
    a_pulse_len: assert property (low_q <= `CMS_PULSE_CYC + 10)
        else $error("status pulse too long");
    a_timer_stop: assert property (tmr_q <= BOOST_TMR_CYC + 8)
        else $error("boost outlived its safety timer");
    c_pulse: cover property ($fell(stat_oe_n));
    c_boost: cover property ($fell(soft_start) && boost_en);
    c_prst: cover property (param_reset);
    c_irq: cover property ($rose(irq));
endmodule
bind cms_top cms_top_sva #(.BOOST_TMR_CYC(BOOST_TMR_CYC)) cms_top_sva_inst (
    .clk(clk), .reset(reset), .wr(wr), .addr(addr), .wdata(wdata),
    .chg_fault(chg_fault), .bst_fault(bst_fault), .vbus_ovp(vbus_ovp),
    .param_reset(param_reset), .charge_en(charge_en), .boost_en(boost_en),
    .soft_start(soft_start), .stat_o(stat_o), .stat_oe_n(stat_oe_n),
    .irq(irq));

// >>> verification/cms_top_tb.sv
// Self-checking bench for the charger mode and fault supervisor
`timescale 1ns/1ps
`include "cms_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
`define WT(c, n) begin for (int k = 0; k < (n) && (c) !== 1'b1; k++) \
    @(posedge clk); `CHK(c, 1'b1) if ((c) !== 1'b1) final_report(); end
module cms_top_tb;
    localparam int TMR = 2000;
    localparam int PL  = `CMS_PULSE_CYC;
    logic clk = 0, reset = 1, wr = 0, rd = 0, rd_q = 0, otg_pin = 0;
    logic vbus_above_uvlo = 0, chg_fault = 0, bst_fault = 0, vbus_ovp = 0;
    logic ind_i_low = 0, node_sag = 0, stat_pin, charge_en, boost_en;
    logic soft_start, pwm_en, param_reset, stat_o, stat_oe_n, irq;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [15:0] ex, exp_q[$];
    int          failures = 0, n_checks = 0, low_len;
    always #50 clk = ~clk;
    cms_top #(.BOOST_TMR_CYC(TMR)) cms_top_inst (.clk(clk), .reset(reset),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .otg_pin(otg_pin), .vbus_above_uvlo(vbus_above_uvlo),
        .chg_fault(chg_fault), .bst_fault(bst_fault), .vbus_ovp(vbus_ovp),
        .ind_i_low(ind_i_low), .node_sag(node_sag), .charge_en(charge_en),
        .boost_en(boost_en), .soft_start(soft_start), .pwm_en(pwm_en),
        .param_reset(param_reset), .stat_o(stat_o), .stat_oe_n(stat_oe_n),
        .irq(irq));
    cms_host_model cms_host_model_inst (.clk(clk), .stat_o(stat_o),
        .stat_oe_n(stat_oe_n), .stat_pin(stat_pin), .low_len(low_len));
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // Read with expected value and care mask noted for the monitor
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, m);
        exp_q.push_back({e, m});
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    // Compares read data in the cycle after each read strobe
    always @(posedge clk) begin
        rd_q <= rd;
        if (rd_q) begin
            ex = exp_q.pop_front();
            `CHK(rdata & ex[7:0], ex[15:8] & ex[7:0])
        end
    end
    initial begin
        void'($urandom(32'h92D5));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        `CHK(stat_oe_n, 1'b1)
        rd_reg(`CMS_ADDR_STAT, 8'h00, 8'h03);
        wr_reg(4'h2, 8'($urandom));
        rd_reg(4'h2, 8'h00, 8'hFF);
        wr_reg(`CMS_ADDR_CTRL, 8'h31);
        `WT(param_reset, 2)
        rd_reg(`CMS_ADDR_CTRL, 8'h00, 8'hFF);
        $display("test reset done");
        vbus_above_uvlo <= 1'b1;
        wr_reg(`CMS_ADDR_MASK, 8'h0F);
        rd_reg(`CMS_ADDR_MASK, 8'h0F, 8'hFF);
        `WT(charge_en, 8)
        wr_reg(`CMS_ADDR_CTRL, 8'h01);
        `WT(!charge_en, 6)
        rd_reg(`CMS_ADDR_STAT, 8'h01, 8'h03);
        wr_reg(`CMS_ADDR_CTRL, 8'h20);
        `WT(!stat_oe_n, 8)
        wr_reg(`CMS_ADDR_CTRL, 8'h00);
        `WT(stat_oe_n, 8)
        chg_fault <= 1'b1;
        `WT(!stat_pin, 8)
        `WT(stat_pin, 1300)
        // Let the meter store the finished stretch
        @(posedge clk);
        `CHK(low_len >= PL && low_len <= PL + 4, 1'b1)
        `CHK(irq, 1'b1)
        rd_reg(`CMS_ADDR_IRQ, 8'h01, 8'h01);
        `WT(!irq, 4)
        rd_reg(`CMS_ADDR_STAT, 8'h01, 8'h03);
        chg_fault <= 1'b0;
        vbus_above_uvlo <= 1'b0;
        wr_reg(`CMS_ADDR_CTRL, 8'h06);
        repeat (8) @(posedge clk);
        `CHK(boost_en, 1'b0)
        $display("test charge done");
        wr_reg(`CMS_ADDR_CTRL, 8'h04);
        `WT(soft_start && boost_en, 6)
        `WT(!soft_start, `CMS_SOFT_CYC + 4)
        `CHK(boost_en, 1'b1)
        ind_i_low <= 1'b1;
        `WT(!pwm_en, 6)
        ind_i_low <= 1'b0;
        rd_reg(`CMS_ADDR_STAT, 8'h43, 8'h43);
        repeat (6) @(posedge clk);
        `CHK(pwm_en, 1'b0)
        node_sag <= 1'b1;
        `WT(pwm_en, 6)
        node_sag <= 1'b0;
        repeat (1400) @(posedge clk);
        wr_reg(`CMS_ADDR_CTRL, 8'h0C);
        rd_reg(`CMS_ADDR_CTRL, 8'h00, 8'h08);
        repeat (1500) @(posedge clk);
        `CHK(boost_en, 1'b1)
        `WT(!boost_en, 600)
        `WT(!stat_pin, 8)
        rd_reg(`CMS_ADDR_STAT, 8'h10, 8'h30);
        rd_reg(`CMS_ADDR_IRQ, 8'h04, 8'h04);
        wr_reg(`CMS_ADDR_CTRL, 8'h40);
        `WT(stat_pin, 1300)
        $display("test boost done");
        otg_pin <= 1'b1;
        `WT(boost_en, 8)
        repeat (300) @(posedge clk);
        vbus_ovp <= 1'b1;
        `WT(!boost_en, 6)
        rd_reg(`CMS_ADDR_CTRL, 8'h00, 8'h04);
        vbus_ovp <= 1'b0;
        `WT(boost_en, 8)
        `WT(stat_pin, 1300)
        wr_reg(`CMS_ADDR_MASK, 8'h00);
        bst_fault <= 1'b1;
        `WT(!boost_en, 6)
        bst_fault <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK(boost_en, 1'b0)
        `CHK(irq, 1'b0)
        rd_reg(`CMS_ADDR_IRQ, 8'h02, 8'h02);
        wr_reg(`CMS_ADDR_CTRL, 8'h40);
        `WT(boost_en, 8)
        $display("test fault done");
        final_report();
    end
endmodule
